// file: src/move_timing_regs.svh
// Encodings, direct addresses, counts and reset values for the move decoder
`ifndef MOVE_TIMING_REGS_SVH
`define MOVE_TIMING_REGS_SVH
// ==========================================================================
// Opcode families (opcode bits 7:3; bits 2:0 select the register)
`define FAM_NONE    5'h00
`define FAM_A_RN    5'h01
`define FAM_A_DIR   5'h02
`define FAM_A_IND   5'h03
`define FAM_A_IMM   5'h04
`define FAM_RN_A    5'h05
`define FAM_RN_DIR  5'h06
`define FAM_RN_IMM  5'h07
`define FAM_DIR_A   5'h08
`define FAM_DIR_RN  5'h09
`define FAM_DIR_DIR 5'h0a
`define FAM_DIR_IND 5'h0b
`define FAM_DIR_IMM 5'h0c
`define FAM_IND_A   5'h0d
`define FAM_IND_DIR 5'h0e
`define FAM_IND_IMM 5'h0f
`define FAM_DP_IMM  5'h10
`define FAM_CT_DP   5'h11
`define FAM_CT_PC   5'h12
`define FAM_XR_IND  5'h13
`define FAM_XW_DP   5'h14
// ==========================================================================
// Direct addresses that map onto core state
`define DIR_ACC     8'he8
`define DIR_STAT    8'hd8
`define DIR_DPL     8'h8a
`define DIR_DPH     8'h8b
// Status fields: bank select and parity
`define STAT_BANK_HI 4
`define STAT_BANK_LO 3
`define STAT_PAR     0
// ==========================================================================
// Counts (bytes, cycles, cycle indices)
`define CNT_ONE     3'h1
`define CNT_TWO     3'h2
`define CNT_THREE   3'h3
`define CT_FIRST    3'h3
`define CT_LAST     3'h6
// States, Gray coded along idle -> operand -> wait
`define ST_IDLE     2'h0
`define ST_OPER     2'h1
`define ST_WAIT     2'h3
// Reset values
`define ACC_RST     8'h00
`define STAT_RST    8'h00
`define DATA_POINTER_RST    16'h0000
`endif

// file: src/move_timing_pkg.sv
// Types shared by the data-move decoder
`include "move_timing_regs.svh"
package move_timing_pkg;
  // ========================================================================
  // Instruction family
  typedef enum logic [4:0] {
    K_NONE = `FAM_NONE,       K_A_RN = `FAM_A_RN,
    K_A_DIR = `FAM_A_DIR,     K_A_IND = `FAM_A_IND,
    K_A_IMM = `FAM_A_IMM,     K_RN_A = `FAM_RN_A,
    K_RN_DIR = `FAM_RN_DIR,   K_RN_IMM = `FAM_RN_IMM,
    K_DIR_A = `FAM_DIR_A,     K_DIR_RN = `FAM_DIR_RN,
    K_DIR_DIR = `FAM_DIR_DIR, K_DIR_IND = `FAM_DIR_IND,
    K_DIR_IMM = `FAM_DIR_IMM, K_IND_A = `FAM_IND_A,
    K_IND_DIR = `FAM_IND_DIR, K_IND_IMM = `FAM_IND_IMM,
    K_DP_IMM = `FAM_DP_IMM,   K_CT_DP = `FAM_CT_DP,
    K_CT_PC = `FAM_CT_PC,     K_XR_IND = `FAM_XR_IND,
    K_XW_DP = `FAM_XW_DP
  } move_kind_t;
  // Sequencer state
  typedef enum logic [1:0] {
    S_IDLE = `ST_IDLE,
    S_OPER = `ST_OPER,
    S_WAIT = `ST_WAIT
  } seq_state_t;
  // Code memory table read request
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } code_req_t;
  // External data request
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } xd_req_t;
  // Visible core state
  typedef struct packed {
    logic [7:0]  acc;
    logic [7:0]  stat;
    logic [15:0] data_pointer;
  } arch_t;
endpackage : move_timing_pkg

// file: src/data_move_timing.sv
// Data-move instruction decoder and sequencer with internal RAM
// Summary of operation
// - A from direct: two bytes, two cycles
// - A from indirect RAM: one byte, two cycles
// - A from immediate: two bytes, two cycles
// - A to working register: one cycle
// - Direct to working register: two, two
// - A to direct: two bytes, two cycles
// - Working register to direct: two, two
// - Indirect RAM to direct: two, two
// - Immediate to direct: three bytes, three cycles
// - A to indirect RAM: one byte, two cycles
// - Immediate to indirect RAM: two, two
// - Data pointer immediate load: three, three
// - Table read via data pointer: 4-7 cycles
// - Table read via PC: 4-7 cycles
// - External read by pointer: one byte, three
// - External write via data pointer: three cycles
`timescale 1ns/1ps
`default_nettype none
`include "move_timing_regs.svh"
module data_move_timing (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // Instruction byte stream
  input  wire logic                       byte_valid,
  input  wire logic [7:0]                 byte_data,
  output logic                            byte_ready_q,
  input  wire logic [15:0]                pc_next,
  // Code memory table port
  output move_timing_pkg::code_req_t      code_q,
  input  wire logic                       code_ack,
  input  wire logic [7:0]                 code_data,
  // External data port
  output move_timing_pkg::xd_req_t        xd_q,
  input  wire logic [7:0]                 xd_rdata,
  // Completion and state
  output logic                            retire_q,
  output move_timing_pkg::arch_t          arch_q
);
  // ========================================================================
  // Declarations
  move_timing_pkg::seq_state_t state_q;   // Sequencer state
  move_timing_pkg::move_kind_t kind_q;    // Latched family
  move_timing_pkg::move_kind_t kind_c;    // Family in force this cycle
  logic [2:0]  rsel_q, rsel_c;            // Register select
  logic [2:0]  cnt_q;                     // Cycle index in instruction
  logic [7:0]  op1_q;                     // First operand byte
  logic [7:0]  iram [256];                // Internal data RAM
  logic        got_q;                     // Table byte already returned
  logic [7:0]  cdata_q;                   // Returned table byte
  logic [2:0]  nbyt_c, ncyc_c;            // Length of current family
  logic        take_c, done_c;            // Opcode taken, move completes
  logic [1:0]  bank_c;                    // Working register bank
  logic [7:0]  rn_a_c, ri_a_c, ptr_c;     // Register and pointer addrs
  logic        wr_acc_c, wr_ram_c, wr_dir_c, wr_dp_c;
  logic [7:0]  ram_a_c, dir_a_c, wdat_c;  // Write address and data
  logic        ram_we_c;                  // Final RAM write enable
  logic        stat_wr_c;                 // Status written by a move

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Length table: {bytes, cycles}
  function automatic logic [5:0] lengths(move_timing_pkg::move_kind_t k);
    case (k)
      move_timing_pkg::K_A_DIR, move_timing_pkg::K_A_IMM,
      move_timing_pkg::K_RN_DIR, move_timing_pkg::K_RN_IMM,
      move_timing_pkg::K_DIR_A, move_timing_pkg::K_DIR_RN,
      move_timing_pkg::K_DIR_IND, move_timing_pkg::K_IND_DIR,
      move_timing_pkg::K_IND_IMM:
        lengths = {`CNT_TWO, `CNT_TWO};
      move_timing_pkg::K_DIR_DIR, move_timing_pkg::K_DIR_IMM,
      move_timing_pkg::K_DP_IMM:
        lengths = {`CNT_THREE, `CNT_THREE};
      move_timing_pkg::K_A_IND, move_timing_pkg::K_IND_A:
        lengths = {`CNT_ONE, `CNT_TWO};
      move_timing_pkg::K_XR_IND, move_timing_pkg::K_XW_DP:
        lengths = {`CNT_ONE, `CNT_THREE};
      move_timing_pkg::K_CT_DP, move_timing_pkg::K_CT_PC:
        lengths = {`CNT_ONE, `CNT_THREE};   // End set by table port
      default:
        lengths = {`CNT_ONE, `CNT_ONE};     // and non-moves
    endcase
  endfunction : lengths

  // Direct-space read: core state or RAM
  function automatic logic [7:0] dir_rd(logic [7:0] a);
    case (a)
      `DIR_ACC:  dir_rd = arch_q.acc;
      `DIR_STAT: dir_rd = arch_q.stat;
      `DIR_DPL:  dir_rd = arch_q.data_pointer[7:0];
      `DIR_DPH:  dir_rd = arch_q.data_pointer[15:8];
      default:   dir_rd = iram[a];
    endcase
  endfunction : dir_rd

  // ========================================================================
  // Decode and sequencing terms
  always_comb
  begin
    // First byte names the family while idle
    kind_c = (state_q == move_timing_pkg::S_IDLE)
           ? move_timing_pkg::move_kind_t'(byte_data[7:3]) : kind_q;
    rsel_c = (state_q == move_timing_pkg::S_IDLE) ? byte_data[2:0] : rsel_q;
    {nbyt_c, ncyc_c} = lengths(kind_c);
    take_c = (state_q == move_timing_pkg::S_IDLE) && byte_valid
           && byte_ready_q;
    bank_c = arch_q.stat[`STAT_BANK_HI:`STAT_BANK_LO];
    rn_a_c = {3'h0, bank_c, rsel_c};
    ri_a_c = {3'h0, bank_c, 2'h0, rsel_c[0]};
    ptr_c  = iram[ri_a_c];
    case (state_q)
      move_timing_pkg::S_IDLE:
        done_c = take_c && (ncyc_c == `CNT_ONE);
      move_timing_pkg::S_OPER:
        done_c = byte_valid && (cnt_q == nbyt_c - `CNT_ONE);
      move_timing_pkg::S_WAIT:
        if (kind_q == move_timing_pkg::K_CT_DP
            || kind_q == move_timing_pkg::K_CT_PC)
          done_c = (cnt_q >= `CT_FIRST && (got_q || code_ack))
                 || (cnt_q == `CT_LAST);
        else
          done_c = (cnt_q == ncyc_c - `CNT_ONE);
      default:
        done_c = 1'b0;
    endcase
  end

  // Sequencer state, cycle index and ready
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q      <= move_timing_pkg::S_IDLE;
      cnt_q        <= 3'h0;
      byte_ready_q <= 1'b0;
      retire_q     <= 1'b0;
    end
    else
    begin
      retire_q <= done_c;
      if (take_c && !done_c)
      begin
        // Operands follow, else wait out the cycles
        state_q      <= (nbyt_c > `CNT_ONE) ? move_timing_pkg::S_OPER
                                            : move_timing_pkg::S_WAIT;
        byte_ready_q <= (nbyt_c > `CNT_ONE);
        cnt_q        <= `CNT_ONE;
      end
      else if (done_c)
      begin
        // Next opcode may follow at once
        state_q      <= move_timing_pkg::S_IDLE;
        byte_ready_q <= 1'b1;
        cnt_q        <= 3'h0;
      end
      else if (state_q == move_timing_pkg::S_WAIT
               || (state_q == move_timing_pkg::S_OPER && byte_valid))
        cnt_q <= cnt_q + `CNT_ONE;   // Missing operand stalls the count
      else if (state_q == move_timing_pkg::S_IDLE)
        byte_ready_q <= 1'b1;
    end
  end

  // Latched family and first operand byte; the last byte is used as it arrives
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      kind_q <= move_timing_pkg::K_NONE;
      rsel_q <= 3'h0;
      op1_q  <= 8'h00;
    end
    else if (take_c)
    begin
      kind_q <= kind_c;
      rsel_q <= byte_data[2:0];
    end
    else if (state_q == move_timing_pkg::S_OPER && byte_valid
             && cnt_q == `CNT_ONE)
      op1_q <= byte_data;
  end

  // ========================================================================
  // Move data path: selects destination and value on completion
  always_comb
  begin
    wr_acc_c = 1'b0;
    wr_ram_c = 1'b0;
    wr_dir_c = 1'b0;
    wr_dp_c  = 1'b0;
    ram_a_c  = rn_a_c;
    dir_a_c  = byte_data;
    wdat_c   = byte_data;
    if (done_c)
      case (kind_c)
        move_timing_pkg::K_A_RN:    {wr_acc_c, wdat_c} = {1'b1, iram[rn_a_c]};
        move_timing_pkg::K_A_DIR:   {wr_acc_c, wdat_c} =
                                      {1'b1, dir_rd(byte_data)};
        move_timing_pkg::K_A_IND:   {wr_acc_c, wdat_c} =
                                      {1'b1, iram[ptr_c]};
        move_timing_pkg::K_A_IMM:   wr_acc_c = 1'b1;
        move_timing_pkg::K_RN_A:    {wr_ram_c, wdat_c} =
                                      {1'b1, arch_q.acc};
        move_timing_pkg::K_RN_DIR:  {wr_ram_c, wdat_c} =
                                      {1'b1, dir_rd(byte_data)};
        move_timing_pkg::K_RN_IMM:  wr_ram_c = 1'b1;
        move_timing_pkg::K_DIR_A:   {wr_dir_c, wdat_c} =
                                      {1'b1, arch_q.acc};
        move_timing_pkg::K_DIR_RN:  {wr_dir_c, wdat_c} =
                                      {1'b1, iram[rn_a_c]};
        move_timing_pkg::K_DIR_DIR: {wr_dir_c, wdat_c} =
                                      {1'b1, dir_rd(op1_q)};
        move_timing_pkg::K_DIR_IND: {wr_dir_c, wdat_c} =
                                      {1'b1, iram[ptr_c]};
        move_timing_pkg::K_DIR_IMM: {wr_dir_c, dir_a_c} =
                                      {1'b1, op1_q};
        move_timing_pkg::K_IND_A:   {wr_ram_c, ram_a_c, wdat_c} =
                                      {1'b1, ptr_c, arch_q.acc};
        move_timing_pkg::K_IND_DIR: {wr_ram_c, ram_a_c, wdat_c} =
                                      {1'b1, ptr_c, dir_rd(byte_data)};
        move_timing_pkg::K_IND_IMM: {wr_ram_c, ram_a_c} =
                                      {1'b1, ptr_c};
        move_timing_pkg::K_DP_IMM:  wr_dp_c = 1'b1;
        move_timing_pkg::K_CT_DP, move_timing_pkg::K_CT_PC:
          {wr_acc_c, wdat_c} = {1'b1, got_q ? cdata_q : code_data};
        move_timing_pkg::K_XR_IND:  {wr_acc_c, wdat_c} =
                                      {1'b1, xd_rdata};
        default:                    wdat_c = byte_data;
      endcase
    // Direct writes to core-state addresses do not reach RAM
    stat_wr_c = wr_dir_c && dir_a_c == `DIR_STAT;
    ram_we_c  = wr_ram_c || (wr_dir_c && dir_a_c != `DIR_ACC && !stat_wr_c
                && dir_a_c != `DIR_DPL && dir_a_c != `DIR_DPH);
  end

  // Internal RAM write port
  always_ff @(posedge clk_sys)
  begin
    if (ram_we_c)
      iram[wr_ram_c ? ram_a_c : dir_a_c] <= wdat_c;
  end

  // Accumulator, status and data pointer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      arch_q <= {`ACC_RST, `STAT_RST, `DATA_POINTER_RST};
    else
    begin
      if (wr_acc_c || (wr_dir_c && dir_a_c == `DIR_ACC))
      begin
        // Only parity follows the accumulator
        arch_q.acc              <= wdat_c;
        arch_q.stat[`STAT_PAR]  <= ^wdat_c;
      end
      if (stat_wr_c)
        arch_q.stat[7:1] <= wdat_c[7:1];
      if (wr_dp_c)
        arch_q.data_pointer <= {op1_q, byte_data};
      else if (wr_dir_c && dir_a_c == `DIR_DPL)
        arch_q.data_pointer[7:0] <= wdat_c;
      else if (wr_dir_c && dir_a_c == `DIR_DPH)
        arch_q.data_pointer[15:8] <= wdat_c;
    end
  end

  // ========================================================================
  // Code table read port: request held until acknowledged or the move completes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      code_q  <= '0;
      got_q   <= 1'b0;
      cdata_q <= 8'h00;
    end
    else if (take_c && (kind_c == move_timing_pkg::K_CT_DP
                        || kind_c == move_timing_pkg::K_CT_PC))
    begin
      code_q.req  <= 1'b1;
      code_q.addr <= {8'h00, arch_q.acc}
                   + ((kind_c == move_timing_pkg::K_CT_DP)
                      ? arch_q.data_pointer : pc_next);
      got_q       <= 1'b0;
    end
    else if (code_q.req && code_ack)
    begin
      code_q.req <= 1'b0;
      got_q      <= 1'b1;
      cdata_q    <= code_data;
    end
    else if (done_c)
      code_q.req <= 1'b0;
  end

  // External data port: one-cycle request after the opcode
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      xd_q <= '0;
    else if (take_c && kind_c == move_timing_pkg::K_XR_IND)
      xd_q <= {1'b1, 1'b0, 8'h00, ptr_c, 8'h00};
    else if (take_c && kind_c == move_timing_pkg::K_XW_DP)
      xd_q <= {1'b1, 1'b1, arch_q.data_pointer, arch_q.acc};
    else
      xd_q.req <= 1'b0;
  end

  // ========================================================================
  // Checks
  sequence s_take(move_timing_pkg::move_kind_t f);
    take_c && kind_c == f;
  endsequence
  sequence s_two(move_timing_pkg::move_kind_t f);
    s_take(f) ##1 byte_valid;
  endsequence

  a_dir_to_acc: assert property (s_two(move_timing_pkg::K_A_DIR)
    |=> retire_q) else $error("direct to A length wrong");
  a_ind_to_acc: assert property (s_take(move_timing_pkg::K_A_IND)
    |-> ##1 !retire_q ##1 retire_q)
    else $error("indirect to A length wrong");
  a_imm_to_acc: assert property (s_two(move_timing_pkg::K_A_IMM)
    |=> retire_q && arch_q.acc == $past(byte_data))
    else $error("immediate to A wrong");
  a_acc_to_reg: assert property (s_take(move_timing_pkg::K_RN_A)
    |=> retire_q) else $error("A to register not one cycle");
  a_acc_to_ind: assert property (s_take(move_timing_pkg::K_IND_A)
    |-> ##1 !retire_q ##1 retire_q)
    else $error("A to indirect length wrong");
  a_imm_to_dir: assert property (s_two(move_timing_pkg::K_DIR_IMM)
    ##1 byte_valid |=> retire_q) else $error("imm to direct wrong");
  a_data_pointer_load: assert property (s_two(move_timing_pkg::K_DP_IMM)
    ##1 byte_valid |=> retire_q && arch_q.data_pointer
    == {$past(byte_data, 2), $past(byte_data)})
    else $error("data pointer load wrong");
  a_table_data_pointer: assert property (s_take(move_timing_pkg::K_CT_DP)
    |=> !retire_q [*3] ##[1:4] retire_q)
    else $error("table read not 4 to 7");
  a_table_pc: assert property (s_take(move_timing_pkg::K_CT_PC)
    |=> !retire_q [*3] ##[1:4] retire_q)
    else $error("pc table read not 4 to 7");
  a_ext_read: assert property (s_take(move_timing_pkg::K_XR_IND)
    |-> ##1 (xd_q.req && !xd_q.we) ##1 !xd_q.req ##1
    (retire_q && arch_q.acc == $past(xd_rdata)))
    else $error("external read wrong");
  a_ext_write: assert property (s_take(move_timing_pkg::K_XW_DP)
    |-> ##1 (xd_q.req && xd_q.we && xd_q.addr == $past(arch_q.data_pointer))
    ##2 retire_q) else $error("external write wrong");
  a_flags_kept: assert property (!stat_wr_c |=>
    arch_q.stat[7:1] == $past(arch_q.stat[7:1]))
    else $error("status changed by move");
endmodule : data_move_timing
`default_nettype wire

// file: tb/move_memories.sv
// Code memory and external data memory facing the move decoder
`timescale 1ns/1ps
`default_nettype none
module move_memories (
  // Clock
  input  wire logic                       clk_sys,
  // Code table port
  input  wire move_timing_pkg::code_req_t code_q,
  input  wire logic [1:0]                 code_lat,
  output logic                            code_ack,
  output logic [7:0]                      code_data,
  // External data port
  input  wire move_timing_pkg::xd_req_t   xd_q,
  output logic [7:0]                      xd_rdata
);
  logic [7:0] xmem [0:65535]; // External data bytes
  logic [1:0] wait_q;         // Cycles the table read has waited
  // Known contents so reads before any write are defined
  initial
  begin
    for (int i = 0; i < 65536; i++)
      xmem[i] = 8'(i ^ (i >> 8));
    code_ack  = 1'b0;
    code_data = 8'h00;
    xd_rdata  = 8'h00;
    wait_q    = 2'h0;
  end
  // ======================================================================
  // Code memory: answer after code_lat idle cycles, bus toggles otherwise
  always @(posedge clk_sys)
  begin
    code_ack  <= 1'b0;
    code_data <= ~code_data;
    if (!code_q.req)
      wait_q <= 2'h0;
    else if (!code_ack && wait_q == code_lat)
    begin
      code_ack  <= 1'b1;
      code_data <= code_q.addr[7:0] ^ code_q.addr[15:8] ^ 8'h3c;
      wait_q    <= 2'h0;
    end
    else if (!code_ack)
      wait_q <= wait_q + 2'h1;
  end
  // ======================================================================
  // External data: write on request, read data shown for one cycle only
  always @(posedge clk_sys)
  begin
    xd_rdata <= ~xd_rdata;
    if (xd_q.req && xd_q.we)
      xmem[xd_q.addr] <= xd_q.wdata;
    else if (xd_q.req)
      xd_rdata <= xmem[xd_q.addr];
  end
endmodule : move_memories
`default_nettype wire

// file: tb/test_data_move_timing.sv
// Random self-checking bench for the data-move decoder
`timescale 1ns/1ps
`default_nettype none
`include "move_timing_regs.svh"
module test_data_move_timing;
  // ======================================================================
  // Signals and expected state
  logic                       clk_sys;
  logic                       rst_n;
  logic                       byte_valid;
  logic [7:0]                 byte_data;
  logic                       byte_ready_q;
  logic [15:0]                pc_next;
  move_timing_pkg::code_req_t code_q;
  logic                       code_ack;
  logic [7:0]                 code_data;
  logic [1:0]                 code_lat;
  move_timing_pkg::xd_req_t   xd_q;
  logic [7:0]                 xd_rdata;
  logic                       retire_q;
  move_timing_pkg::arch_t     arch_q;
  int                         fails;
  int                         cmp_count;
  int                         cyc;
  int                         takes;
  logic [7:0]                 ram [0:255]; // Expected internal RAM
  logic [7:0]                 acc;
  logic [7:0]                 st;
  logic [15:0]                dp;
  logic [15:0]                xaddr;       // Expected external address
  data_move_timing data_move_timing_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready_q(byte_ready_q), .pc_next(pc_next),
    .code_q(code_q), .code_ack(code_ack), .code_data(code_data),
    .xd_q(xd_q), .xd_rdata(xd_rdata), .retire_q(retire_q), .arch_q(arch_q));
  move_memories move_memories_i (
    .clk_sys(clk_sys), .code_q(code_q), .code_lat(code_lat),
    .code_ack(code_ack), .code_data(code_data), .xd_q(xd_q),
    .xd_rdata(xd_rdata));
  // Clock, cycle count, byte takes and hang guard
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (byte_valid && byte_ready_q)
      takes <= takes + 1;
    if (cyc == 20000)
    begin
      fails = fails + 1;
      final_report();
    end
  end
  // ======================================================================
  // Reporting
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // ======================================================================
  // Reference behaviour
  function automatic logic [7:0] rd(input logic [7:0] a);
    case (a)
      `DIR_ACC:  return acc;
      `DIR_STAT: return {st[7:1], ^acc};
      `DIR_DPL:  return dp[7:0];
      `DIR_DPH:  return dp[15:8];
      default:   return ram[a];
    endcase
  endfunction : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    case (a)
      `DIR_ACC:  acc = v;
      `DIR_STAT: st[7:1] = v[7:1];
      `DIR_DPL:  dp[7:0] = v;
      `DIR_DPH:  dp[15:8] = v;
      default:   ram[a] = v;
    endcase
  endtask : wr
  function automatic logic [7:0] cb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : cb
  function automatic int nb(input logic [4:0] f);
    case (f)
      `FAM_DIR_DIR, `FAM_DIR_IMM, `FAM_DP_IMM: return 3;
      `FAM_A_RN, `FAM_A_IND, `FAM_RN_A, `FAM_IND_A, `FAM_CT_DP,
      `FAM_CT_PC, `FAM_XR_IND, `FAM_XW_DP: return 1;
      default: return 2;
    endcase
  endfunction : nb
  task automatic exec(input logic [4:0] f, input logic [2:0] r,
                      input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] ra;
    logic [7:0] pa;
    ra = {3'h0, st[4:3], r};
    pa = ram[{3'h0, st[4:3], 2'h0, r[0]}];
    xaddr = (f == `FAM_XW_DP) ? dp : {8'h00, pa};
    case (f)
      `FAM_A_RN:    acc = ram[ra];
      `FAM_A_DIR:   acc = rd(b1);
      `FAM_A_IND:   acc = ram[pa];
      `FAM_A_IMM:   acc = b1;
      `FAM_RN_A:    ram[ra] = acc;
      `FAM_RN_DIR:  ram[ra] = rd(b1);
      `FAM_RN_IMM:  ram[ra] = b1;
      `FAM_DIR_A:   wr(b1, acc);
      `FAM_DIR_RN:  wr(b1, ram[ra]);
      `FAM_DIR_DIR: wr(b2, rd(b1));
      `FAM_DIR_IND: wr(b1, ram[pa]);
      `FAM_DIR_IMM: wr(b1, b2);
      `FAM_IND_A:   ram[pa] = acc;
      `FAM_IND_DIR: ram[pa] = rd(b1);
      `FAM_IND_IMM: ram[pa] = b1;
      `FAM_DP_IMM:  dp = {b1, b2};
      `FAM_CT_DP:   acc = cb(acc + dp);
      `FAM_CT_PC:   acc = cb(acc + pc_next);
      `FAM_XR_IND:  acc = move_memories_i.xmem[xaddr];
      default:      ;
    endcase
  endtask : exec
  // ======================================================================
  // Drivers
  task automatic do_reset();
    rst_n      = 1'b0;
    byte_valid = 1'b0;
    byte_data  = 8'h00;
    pc_next    = 16'h0000;
    code_lat   = 2'h0;
    {acc, st, dp} = 32'h0;
    repeat (8) @(negedge clk_sys);
    chk(arch_q, 32'h0);
    chk({byte_ready_q, retire_q, code_q.req, xd_q.req}, 32'h0);
    rst_n = 1'b1;
    @(negedge clk_sys);
    chk(byte_ready_q, 32'h1);
  endtask : do_reset
  // Send one instruction back to back, refuse-test the wait, then check
  task automatic run(input logic [4:0] f, input logic [2:0] r,
                     input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] bt [3];
    int         t0;
    int         k0;
    int         dur;
    bt = '{{f, r}, b1, b2};
    code_lat = 2'($urandom_range(0, 3));
    pc_next  = 16'($urandom);
    exec(f, r, b1, b2);
    k0 = takes;
    for (int k = 0; k < nb(f); k++)
    begin
      while (byte_ready_q !== 1'b1)
      begin
        byte_valid = 1'b0;
        @(negedge clk_sys);
      end
      byte_valid = 1'b1;
      byte_data  = bt[k];
      if (k == 0)
        t0 = cyc;
      @(negedge clk_sys);
    end
    while (retire_q !== 1'b1)
    begin
      byte_valid = (byte_ready_q === 1'b0);
      byte_data  = 8'($urandom);
      @(negedge clk_sys);
    end
    dur = cyc - t0;
    chk(takes - k0, nb(f));
    chk(arch_q, {acc, st[7:1], ^acc, dp});
    case (f)
      `FAM_A_DIR, `FAM_A_IMM, `FAM_RN_DIR:
        chk(dur, 2);
      `FAM_DIR_A, `FAM_DIR_RN, `FAM_DIR_IND:
        chk(dur, 2);
      `FAM_A_IND, `FAM_IND_A, `FAM_IND_IMM:
        chk(dur, 2);
      `FAM_DIR_IMM, `FAM_DP_IMM:
        chk(dur, 3);
      `FAM_CT_DP, `FAM_CT_PC:
        chk(dur, (code_lat == 2'h0) ? 4 : 3 + code_lat);
      `FAM_XR_IND, `FAM_XW_DP:
        chk(dur, 3);
      `FAM_RN_A:
        chk(dur, 1);
      default:
        chk(dur, nb(f));
    endcase
    if (f == `FAM_XR_IND || f == `FAM_XW_DP)
    begin
      chk({xd_q.we, xd_q.addr}, {f == `FAM_XW_DP, xaddr});
      chk(move_memories_i.xmem[xaddr], acc);
    end
  endtask : run
  function automatic logic [7:0] adr();
    logic [7:0] s [4] = '{`DIR_ACC, `DIR_STAT, `DIR_DPL, `DIR_DPH};
    if ($urandom_range(0, 3) != 0)
      return 8'($urandom_range(0, 127));
    return s[$urandom_range(0, 3)];
  endfunction : adr
  // ======================================================================
  // Main sequence
  initial
  begin
    logic [4:0] f;
    logic [7:0] b1;
    logic [7:0] b2;
    fails     = 0;
    cmp_count = 0;
    cyc       = 0;
    takes     = 0;
    void'($urandom(43));
    do_reset();
    $display("Test reset done");
    for (int a = 128; a < 256; a++)
    begin
      run(`FAM_RN_IMM, 3'h0, 8'(a), 8'h00);
      run(`FAM_IND_IMM, 3'h0, 8'($urandom), 8'h00);
    end
    for (int a = 0; a < 128; a++)
      run(`FAM_DIR_IMM, 3'h0, 8'(a), 8'($urandom));
    $display("Test fill done");
    // Pointer wrap on table read, status write with parity bit set
    run(`FAM_DP_IMM, 3'h0, 8'hff, 8'hff);
    run(`FAM_A_IMM, 3'h0, 8'h02, 8'h00);
    run(`FAM_CT_DP, 3'h0, 8'h00, 8'h00);
    run(`FAM_DIR_IMM, 3'h0, `DIR_STAT, 8'hff);
    run(`FAM_DIR_DIR, 3'h1, `DIR_STAT, 8'h30);
    run(`FAM_XW_DP, 3'h0, 8'h00, 8'h00);
    do_reset();
    $display("Test corners done");
    for (int i = 0; i < 1500; i++)
    begin
      f  = 5'($urandom_range(1, 20));
      b1 = (f inside {`FAM_A_IMM, `FAM_RN_IMM, `FAM_IND_IMM, `FAM_DP_IMM})
           ? 8'($urandom) : adr();
      b2 = (f inside {`FAM_DIR_IMM, `FAM_DP_IMM}) ? 8'($urandom) : adr();
      run(f, 3'($urandom), b1, b2);
    end
    byte_valid = 1'b0;
    $display("Test random done");
    final_report();
  end
endmodule : test_data_move_timing
`default_nettype wire
